// >>> hdl/kmc_host.sv
module kmc_host #(
	parameter int INHIBIT_CYCLES = kmc_pkg::INHIBIT_CYCLES,
	parameter int TIMEOUT_CYCLES = kmc_pkg::TIMEOUT_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_option,
	input wire logic [4:0] repeat_rate,
	input wire logic [1:0] repeat_delay,
	output logic cmd_ready,
	output logic done,
	output logic cmd_ok,
	output logic cmd_err,
	output logic selftest_pass,
	output logic [7:0] last_rx,
	output logic [7:0] status0,
	output logic [7:0] status1,
	output logic [7:0] status2,
	output logic btn_right,
	output logic btn_middle,
	output logic btn_left,
	input wire logic link_clk_in,
	output logic link_clk_out,
	output logic link_clk_oe,
	input wire logic link_data_in,
	output logic link_data_out,
	output logic link_data_oe
);
	// =====================================================
	// pin synchronisers and edge find
	logic clk_s1, clk_s2, clk_d, dat_s1, dat_s2;
	always_ff @(posedge clock) begin
		clk_s1 <= link_clk_in;
		clk_s2 <= clk_s1;
		clk_d <= clk_s2;
		dat_s1 <= link_data_in;
		dat_s2 <= dat_s1;
	end
	wire logic fall = clk_d & ~clk_s2;

	// =====================================================
	// command decode
	kmc_pkg::kmc_state_e state;
	logic [7:0] cmd, opt, rx_shift;
	logic [8:0] tx_frame;
	logic [3:0] bit_cnt;
	logic [1:0] extra, sidx;
	logic opt_pend, opt_sent, got_ack;
	logic [31:0] timer;
	wire logic is_repeat = cmd_code == kmc_pkg::CMD_SET_REPEAT;
	wire logic is_res = cmd_code == kmc_pkg::CMD_SET_RES;
	wire logic [7:0] repeat_opt = {1'b0, repeat_delay, repeat_rate};
	wire logic [7:0] res_opt = {6'h00, cmd_option[kmc_pkg::RES_W-1:0]};
	wire logic [7:0] opt_sel = is_repeat ? repeat_opt : (is_res ? res_opt : cmd_option);
	// data bytes that follow the ack
	wire logic [1:0] extra_sel = (cmd_code == kmc_pkg::CMD_STATUS) ? 2'd3 :
		(cmd_code == kmc_pkg::CMD_RESET || cmd_code == kmc_pkg::CMD_RESEND) ? 2'd1 : 2'd0;
	wire logic [7:0] rx_byte = rx_shift;
	// odd parity over the eight data bits and the received parity bit
	wire logic rx_par_ok = ^{rx_shift, rx_par} == 1'b1;
	wire logic [7:0] tx_byte = opt_sent ? opt : cmd;
	wire logic timeout = timer >= 32'(TIMEOUT_CYCLES);
	wire logic inhibit_end = timer >= 32'(INHIBIT_CYCLES);
	wire logic is_ack = rx_byte == kmc_pkg::RSP_ACK;
	wire logic is_resend = rx_byte == kmc_pkg::RSP_RESEND;
	logic rx_par;

	// =====================================================
	// sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= kmc_pkg::ST_IDLE;
			cmd <= kmc_pkg::BYTE_RESET;
			opt <= kmc_pkg::BYTE_RESET;
			rx_shift <= kmc_pkg::BYTE_RESET;
			tx_frame <= 9'h000;
			bit_cnt <= 4'h0;
			extra <= 2'd0;
			sidx <= 2'd0;
			opt_pend <= 1'b0;
			opt_sent <= 1'b0;
			got_ack <= 1'b0;
			timer <= 32'h0;
			rx_par <= 1'b0;
			cmd_ready <= 1'b0;
			done <= 1'b0;
			cmd_ok <= 1'b0;
			cmd_err <= 1'b0;
			selftest_pass <= 1'b0;
			last_rx <= kmc_pkg::BYTE_RESET;
			status0 <= kmc_pkg::BYTE_RESET;
			status1 <= kmc_pkg::BYTE_RESET;
			status2 <= kmc_pkg::BYTE_RESET;
			link_clk_oe <= 1'b0;
			link_data_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			timer <= timer + 32'h1;
			case (state)
				kmc_pkg::ST_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						cmd <= cmd_code;
						opt <= opt_sel;
						opt_pend <= is_repeat | is_res;
						opt_sent <= 1'b0;
						got_ack <= 1'b0;
						extra <= extra_sel;
						sidx <= 2'd0;
						cmd_ok <= 1'b0;
						cmd_err <= 1'b0;
						timer <= 32'h0;
						state <= kmc_pkg::ST_INHIBIT;
					end
				end
				kmc_pkg::ST_INHIBIT: begin
					link_clk_oe <= 1'b1;
					tx_frame <= {~^tx_byte, tx_byte};
					if (inhibit_end) begin
						link_data_oe <= 1'b1;
						state <= kmc_pkg::ST_REQUEST;
					end
				end
				kmc_pkg::ST_REQUEST: begin
					link_clk_oe <= 1'b0;
					bit_cnt <= 4'h0;
					timer <= 32'h0;
					state <= kmc_pkg::ST_TX;
				end
				kmc_pkg::ST_TX: begin
					if (fall) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt <= kmc_pkg::TX_PARITY_IDX)
							link_data_oe <= ~tx_frame[bit_cnt];
						else if (bit_cnt == kmc_pkg::TX_STOP_IDX)
							link_data_oe <= 1'b0;
						else begin
							timer <= 32'h0;
							state <= dat_s2 ? kmc_pkg::ST_DONE : kmc_pkg::ST_WAIT_RX;
							cmd_err <= dat_s2;
						end
					end else if (timeout) begin
						link_data_oe <= 1'b0;
						cmd_err <= 1'b1;
						state <= kmc_pkg::ST_DONE;
					end
				end
				kmc_pkg::ST_WAIT_RX: begin
					bit_cnt <= 4'h0;
					if (fall && !dat_s2)
						state <= kmc_pkg::ST_RX;
					else if (timeout) begin
						cmd_err <= 1'b1;
						state <= kmc_pkg::ST_DONE;
					end
				end
				kmc_pkg::ST_RX: begin
					if (fall) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt < kmc_pkg::TX_PARITY_IDX)
							rx_shift <= {dat_s2, rx_shift[7:1]};
						else if (bit_cnt == kmc_pkg::TX_PARITY_IDX)
							rx_par <= dat_s2;
						else begin
							timer <= 32'h0;
							last_rx <= rx_byte;
							state <= kmc_pkg::ST_WAIT_RX;
							if (!dat_s2 || !rx_par_ok) begin
								cmd_err <= 1'b1;
								state <= kmc_pkg::ST_DONE;
							end else if (!got_ack) begin
								if (is_resend) begin
									state <= kmc_pkg::ST_INHIBIT; // repeat our byte
								end else if (!is_ack) begin
									cmd_err <= 1'b1;
									state <= kmc_pkg::ST_DONE;
								end else if (opt_pend) begin
									opt_pend <= 1'b0;
									opt_sent <= 1'b1;
									state <= kmc_pkg::ST_INHIBIT;
								end else begin
									got_ack <= 1'b1;
									if (extra == 2'd0) begin
										cmd_ok <= 1'b1;
										state <= kmc_pkg::ST_DONE;
									end
								end
							end else begin
								sidx <= sidx + 2'd1;
								if (sidx == 2'd0)
									status0 <= rx_byte;
								if (sidx == 2'd1)
									status1 <= rx_byte;
								if (sidx == 2'd2)
									status2 <= rx_byte;
								if (sidx + 2'd1 == extra) begin
									state <= kmc_pkg::ST_DONE;
									if (cmd == kmc_pkg::CMD_RESET) begin
										selftest_pass <= rx_byte == kmc_pkg::RSP_TEST_PASS;
										cmd_ok <= rx_byte == kmc_pkg::RSP_TEST_PASS;
										cmd_err <= rx_byte != kmc_pkg::RSP_TEST_PASS;
									end else
										cmd_ok <= 1'b1;
								end
							end
						end
					end else if (timeout) begin
						cmd_err <= 1'b1;
						state <= kmc_pkg::ST_DONE;
					end
				end
				kmc_pkg::ST_DONE: begin
					link_data_oe <= 1'b0;
					link_clk_oe <= 1'b0;
					done <= 1'b1;
					state <= kmc_pkg::ST_IDLE;
				end
				default: state <= kmc_pkg::ST_IDLE;
			endcase
		end
	end

	// =====================================================
	// button view of status byte one
	always_ff @(posedge clock) begin
		if (rst) begin
			btn_right <= 1'b0;
			btn_middle <= 1'b0;
			btn_left <= 1'b0;
			link_clk_out <= 1'b0;
			link_data_out <= 1'b0;
		end else begin
			btn_right <= status0[kmc_pkg::BTN_RIGHT];
			btn_middle <= status0[kmc_pkg::BTN_MIDDLE];
			btn_left <= status0[kmc_pkg::BTN_LEFT];
		end
	end

	// =====================================================
	// checks
	wire logic opt_start = state == kmc_pkg::ST_RX && fall && bit_cnt == kmc_pkg::TX_STOP_IDX
		&& opt_pend && !got_ack && is_ack && dat_s2 && rx_par_ok;
	chk_opt_after_ack: assert property (@(posedge clock) disable iff (rst)
		(state == kmc_pkg::ST_TX && opt_sent) |-> !opt_pend)
		else $error("option byte sent with option still pending");
	chk_opt_two_byte: assert property (@(posedge clock) disable iff (rst)
		opt_start |=> state == kmc_pkg::ST_INHIBIT && opt_sent)
		else $error("no option byte after first ack");
	chk_repeat_pack: assert property (@(posedge clock) disable iff (rst)
		(cmd_valid && cmd_ready && is_repeat) |=> !opt[7] && opt[6:5] == $past(repeat_delay))
		else $error("repeat option byte packed wrong");
	chk_res_range: assert property (@(posedge clock) disable iff (rst)
		(cmd_valid && cmd_ready && is_res) |=> opt[7:2] == 6'h00)
		else $error("resolution option out of range");
	chk_inhibit_clk: assert property (@(posedge clock) disable iff (rst)
		state == kmc_pkg::ST_REQUEST |-> link_clk_oe && link_data_oe)
		else $error("request without clock inhibit and data low");
	chk_done_pulse: assert property (@(posedge clock) disable iff (rst)
		done |=> !done && state == kmc_pkg::ST_IDLE && cmd_ready)
		else $error("done not a single pulse");
	chk_done_result: assert property (@(posedge clock) disable iff (rst)
		done |-> cmd_ok != cmd_err)
		else $error("done without single outcome");
	chk_btn_follow: assert property (@(posedge clock) disable iff (rst)
		##1 btn_right == $past(status0[0]) && btn_middle == $past(status0[1])
		&& btn_left == $past(status0[2]))
		else $error("buttons do not follow status");
	cov_status: cover property (@(posedge clock) done && cmd_ok && cmd == kmc_pkg::CMD_STATUS);
	cov_repeat: cover property (@(posedge clock) done && cmd_ok && cmd == kmc_pkg::CMD_SET_REPEAT);
	cov_reset: cover property (@(posedge clock) done && cmd == kmc_pkg::CMD_RESET);
	cov_err: cover property (@(posedge clock) done && cmd_err);
endmodule // kmc_host

// >>> hdl/kmc_pkg.sv
// How it works
// - F3h asks new auto-repeat rate and delay
// - ack follows F3h, then option byte next
// - option bits 0-4 set repeat rate
// - option bits 5-6 set delay, bit7 ignored
// - second ack after the auto-repeat option
// - enable F4h flushes, scans, answers FAh
// - disable F5h resets, acks, stops scanning
// - resend FEh acks then repeats last byte
// - reset FFh acks, self-tests, sends AAh/FCh
// - E6h acks and selects 1:1 scaling
// - E7h acks and selects 2:1 scaling
// - E8h acks, then option 00h-03h resolution
// - second ack after resolution option byte
// - E9h acks then sends three status bytes
// - status byte one bit0 is right button
// - bit1 middle button, bit2 left button
package kmc_pkg;
	localparam logic [7:0] CMD_SET_REPEAT = 8'hF3;
	localparam logic [7:0] CMD_ENABLE = 8'hF4;
	localparam logic [7:0] CMD_DISABLE = 8'hF5;
	localparam logic [7:0] CMD_RESEND = 8'hFE;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_SCALE_1 = 8'hE6;
	localparam logic [7:0] CMD_SCALE_2 = 8'hE7;
	localparam logic [7:0] CMD_SET_RES = 8'hE8;
	localparam logic [7:0] CMD_STATUS = 8'hE9;
	localparam logic [7:0] RSP_ACK = 8'hFA;
	localparam logic [7:0] RSP_TEST_PASS = 8'hAA;
	localparam logic [7:0] RSP_TEST_FAIL = 8'hFC;
	localparam logic [7:0] RSP_RESEND = 8'hFE;
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 5;
	localparam int DELAY_LSB = 5;
	localparam int DELAY_W = 2;
	localparam int RES_W = 2;
	localparam int BTN_RIGHT = 0;
	localparam int BTN_MIDDLE = 1;
	localparam int BTN_LEFT = 2;
	localparam int STATUS_BYTES = 3;
	localparam int CLK_MHZ = 100;
	localparam int INHIBIT_US = 100;
	localparam int TIMEOUT_US = 20000;
	localparam int INHIBIT_CYCLES = INHIBIT_US * CLK_MHZ;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
	localparam logic [3:0] TX_PARITY_IDX = 4'h8;
	localparam logic [3:0] TX_STOP_IDX = 4'h9;
	localparam logic [3:0] TX_ACK_IDX = 4'hA;
	localparam logic [3:0] RX_LAST_IDX = 4'h9;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_INHIBIT = 3'b001,
		ST_REQUEST = 3'b010,
		ST_TX = 3'b011,
		ST_WAIT_RX = 3'b100,
		ST_RX = 3'b101,
		ST_DONE = 3'b110
	} kmc_state_e;
endpackage

// >>> sim/kmc_dev_model.sv
module kmc_dev_model (
	input wire logic clk_line,
	input wire logic data_line,
	output logic clk_drv,
	output logic data_drv,
	input wire logic test_fail,
	input wire logic [2:0] buttons
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SAMPLE_RATE = 8'h64;
	logic [7:0] rx_log [$];
	logic [7:0] last_tx, cmd, prev;
	logic [7:0] rate_dly = 8'h00;
	logic [1:0] res = 2'h0;
	logic scale2 = 0, want_opt = 0, scanning = 1;
	// ==========
	// framing, clock made only inside frames
	task automatic tx(input logic [7:0] b);
		logic [10:0] f;
		f = {1'h1, ~^b, b, 1'h0};
		for (int i = 0; i < 11; i++) begin
			data_drv = ~f[i];
			#40 clk_drv = 1;
			#80 clk_drv = 0;
			#40;
		end
		last_tx = b;
	endtask
	task automatic rx(output logic [7:0] b);
		for (int i = 1; i < 12; i++) begin
			#40 clk_drv = 1;
			#80 clk_drv = 0;
			if (i < 9) b[i-1] = data_line;
			if (i == 10) data_drv = 1;
		end
		#80 data_drv = 0;
		// gap so a reply frame never starts in the release step
		#40;
	endtask
	initial begin
		clk_drv = 0;
		data_drv = 0;
		forever begin
			wait (clk_line === 1'h0);
			wait (clk_line === 1'h1 && data_line === 1'h0);
			prev = last_tx;
			rx(cmd);
			rx_log.push_back(cmd);
			if (want_opt) begin
				want_opt = 0;
				if (rx_log[$-1] == 8'hE8) res = cmd[1:0];
				else rate_dly = cmd;
				tx(8'hFA);
			end else begin
				case (cmd)
					8'hF3, 8'hE8: begin
						tx(8'hFA);
						want_opt = 1;
					end
					8'hF4, 8'hF5: begin
						scanning = ~cmd[0];
						tx(8'hFA);
					end
					8'hE6, 8'hE7: begin
						scale2 = cmd[0];
						tx(8'hFA);
					end
					8'hFE: begin
						tx(8'hFA);
						tx(prev);
					end
					8'hFF: begin
						tx(8'hFA);
						tx(test_fail ? 8'hFC : 8'hAA);
					end
					8'hE9: begin
						tx(8'hFA);
						tx({3'h0, scale2, 1'h0, buttons});
						tx({6'h0, res});
						tx(SAMPLE_RATE);
					end
					default: tx(8'hFA);
				endcase
			end
		end
	end
endmodule // kmc_dev_model

// >>> sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0;
	logic rst = 1;
	logic cmd_valid = 0;
	logic [7:0] cmd_code = 8'h00;
	logic [7:0] cmd_option = 8'h00;
	logic [4:0] repeat_rate = 5'h00;
	logic [1:0] repeat_delay = 2'h0;
	logic test_fail = 0;
	logic [2:0] buttons = 3'h0;
	logic cmd_ready, done, cmd_ok, cmd_err, selftest_pass;
	logic btn_right, btn_middle, btn_left;
	logic [7:0] last_rx, status0, status1, status2;
	logic clk_oe, data_oe, clk_drv, data_drv;
	logic clk_out, data_out;
	wire clk_line = ~(clk_oe | clk_drv);
	wire data_line = ~(data_oe | data_drv);
	int mismatches = 0;
	int n_checks = 0;
	always #5 clock = ~clock;
	kmc_host #(.INHIBIT_CYCLES(20), .TIMEOUT_CYCLES(5000)) dut_u (
		.clock, .rst, .cmd_valid, .cmd_code, .cmd_option, .repeat_rate, .repeat_delay,
		.cmd_ready, .done, .cmd_ok, .cmd_err, .selftest_pass, .last_rx, .status0, .status1,
		.status2, .btn_right, .btn_middle, .btn_left, .link_clk_in(clk_line),
		.link_clk_out(clk_out), .link_clk_oe(clk_oe), .link_data_in(data_line),
		.link_data_out(data_out), .link_data_oe(data_oe)
	);
	kmc_dev_model dev (.clk_line, .data_line, .clk_drv, .data_drv, .test_fail, .buttons);
	// ==========
	// compare and command tasks
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] code, input logic [7:0] opt);
		int n;
		n = 0;
		do @(negedge clock); while (cmd_ready !== 1'h1);
		cmd_code = code;
		cmd_option = opt;
		cmd_valid = 1;
		@(negedge clock);
		cmd_valid = 0;
		while (done !== 1'h1 && n < 20000) begin
			@(negedge clock);
			n++;
		end
		check("done", 8'h01, {7'h0, done});
	endtask
	// ==========
	// scenarios
	task automatic t_repeat;
		for (int i = 0; i < 2; i++) begin
			repeat_rate = i ? 5'h1F : 5'h00;
			repeat_delay = i ? 2'h3 : 2'h0;
			send(8'hF3, 8'h80);
			check("repeat ok", 8'h01, {7'h0, cmd_ok});
			check("repeat cmd", 8'hF3, dev.rx_log[$-1]);
			check("repeat opt", i ? 8'h7F : 8'h00, dev.rx_log[$]);
		end
		$display("repeat test done");
	endtask
	task automatic t_keyboard;
		send(8'hF4, 8'h00);
		check("enable ok", 8'h01, {7'h0, cmd_ok});
		send(8'hF5, 8'h00);
		check("disable ack", 8'hFA, last_rx);
		check("pin drive level", 8'h00, {6'h00, clk_out, data_out});
		$display("keyboard test done");
	endtask
	task automatic t_reset;
		for (int i = 0; i < 2; i++) begin
			test_fail = i[0];
			send(8'hFF, 8'h00);
			check("test code", i ? 8'hFC : 8'hAA, status0);
			check("test pass", {7'h0, !i[0]}, {7'h0, selftest_pass});
			check("test err", {7'h0, i[0]}, {7'h0, cmd_err});
		end
		$display("reset test done");
	endtask
	task automatic t_mouse;
		for (int i = 0; i < 4; i++) begin
			buttons = 3'(i + 5);
			send(i[0] ? 8'hE7 : 8'hE6, 8'h00);
			send(8'hE8, 8'(i));
			check("res ok", 8'h01, {7'h0, cmd_ok});
			send(8'hE9, 8'h00);
			@(negedge clock);
			check("status0", {3'h0, i[0], 1'h0, 3'(i + 5)}, status0);
			check("status1", 8'(i), status1);
			check("status2", dev.SAMPLE_RATE, status2);
			check("buttons", {5'h0, 3'(i + 5)}, {5'h0, btn_left, btn_middle, btn_right});
		end
		$display("mouse test done");
	endtask
	task automatic t_resend;
		send(8'hFE, 8'h00);
		check("resent", dev.SAMPLE_RATE, status0);
		$display("resend test done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		finish_test;
	end
	initial begin
		repeat (3) @(negedge clock);
		rst = 0;
		t_repeat;
		t_keyboard;
		t_reset;
		t_mouse;
		t_resend;
		finish_test;
	end
endmodule // tb_top
